// ---- bench/slc_checker_test.sv ----
`timescale 1ns/1ps
module slc_checker_test import slc_pkg::*; ;
    logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stack_trap;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    slc_req_t    req;
    slc_mem_t    mem;
    int          fails = 0, num_checks = 0, traps = 0;
    // clock, parts and trap count
    always #12.5 mclk = ~mclk;
    slc_core_model u_core (.mclk, .req);
    slc_checker u_dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .req, .mem, .stack_trap);
    always @(posedge mclk) if (stack_trap === 1'b1) traps++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) fails++;
        if (got !== exp) $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge mclk);
        {reg_wr, reg_rd} <= 2'b00;
        #1 if (!w) chk(reg_rdata, d);
    endtask
    // pops below the floor, then pushes through the limit
    task automatic t_stack();
        bus(1'b1, 4'h0, 16'h0805);
        bus(1'b0, 4'h0, 16'h0804);
        bus(1'b0, 4'h3, 16'h0000);
        bus(1'b1, 4'h1, 16'h0803);
        for (int i = 0; i < 2; i++) u_core.issue(SLC_OP_POP, 1'b0, 1'b0, 16'h0000);
        u_core.issue(SLC_OP_EA, 1'b0, 1'b0, 16'h0701);
        for (int i = 0; i < 5; i++) u_core.issue(SLC_OP_PUSH, i == 2, i == 1, 16'h1234);
        u_core.issue(SLC_OP_NONE, 1'b0, 1'b0, 16'h0000);
        bus(1'b0, 4'h1, 16'h0808);
        chk(16'(traps), 16'h0004);
        bus(1'b0, 4'h2, 16'h0003);
    endtask
    // one call push checked at the port, then the sticky flags cleared
    task automatic t_push_port();
        bus(1'b1, 4'h0, 16'h0ffe);
        bus(1'b1, 4'h1, 16'h0900);
        u_core.issue(SLC_OP_PUSH, 1'b0, 1'b1, 16'h1234);
        u_core.issue(SLC_OP_NONE, 1'b0, 1'b0, 16'h0000);
        #1 chk(mem.addr, 16'h0900);
        chk(mem.wdata, 16'h0034);
        chk({15'h0000, mem.write}, 16'h0001);
        chk({15'h0000, stack_trap}, 16'h0000);
        bus(1'b1, 4'h2, 16'h0003);
        bus(1'b0, 4'h2, 16'h0000);
    endtask
    initial begin // reset, then the scenarios
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_stack();
        t_push_port();
        close_out(0);
    end
    initial #20000 close_out(1); // watchdog
    task automatic close_out(input int late);
        fails += late;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
endmodule

// ---- bench/slc_core_model.sv ----
`timescale 1ns/1ps
module slc_core_model
    import slc_pkg::*;
(
    input wire logic mclk,
    output slc_req_t req = '0
);
    task automatic issue(input slc_op_t op, input logic e, input logic p, input logic [15:0] d);
        @(posedge mclk);
        req <= '{op, e, p, d, d, 8'ha5}; // one request per edge
    endtask
endmodule

// ---- bench/slc_stack_checker.sv ----
`timescale 1ns/1ps
module slc_props
    import slc_pkg::*;
(
    // watched top ports
    input wire logic mclk,
    input wire logic rst,
    input slc_req_t  req,
    input slc_mem_t  mem,
    input wire logic stack_trap
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic push = req.op == SLC_OP_PUSH;
    sequence s_two_push; push [*2]; endsequence
    a_push_step: assert property (s_two_push |=> mem.addr == $past(mem.addr) + 16'h2)
        else $error("push step");
    a_push_wr: assert property (push |=> mem.valid && mem.write) else $error("push");
    a_pop_rd: assert property (req.op == SLC_OP_POP
        |=> mem.valid && !mem.write) else $error("pop");
    a_call_upper: assert property (push && req.pc_push && !req.exc_push
        |=> mem.wdata[15:8] == 8'h00) else $error("call");
    a_exc_srl: assert property (push && req.exc_push
        |=> mem.wdata[15:8] == $past(req.status_low_byte)) else $error("srl");
    a_addr_even: assert property (mem.valid |-> !mem.addr[0]) else $error("odd");
    a_low_trap: assert property (mem.valid && mem.addr < 16'h0800
        |-> stack_trap) else $error("under");
    a_trap_src: assert property (stack_trap |-> mem.valid) else $error("trap");
endmodule
bind slc_checker slc_props u_props (.mclk, .rst, .req, .mem, .stack_trap);

// ---- logic/slc_checker.sv ----
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "slc_regs.svh"

// Notes on behaviour
// - working_reg_fifteen is the stack pointer; points to next free word, grows upward.
// - push writes at pointer then increments; pop decrements first then reads.
// - call pushes of the program counter clear the upper byte, unless exc_push is also set.
// - exception pushes put status_low_byte into the upper byte.
// - stack_limit has no reset value; undefined until software writes it.
// - bit 0 of stack_limit and of the stack pointer forced to zero.
// - every pointer-based effective address is compared against stack_limit.
// - push at pointer equal to limit is fine; the next push traps.
// - pointer-based address below 0x0800 raises the stack error trap.
module slc_checker
    import slc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // core request
    input  slc_req_t         req,
    // memory access and trap
    output slc_mem_t         mem,
    output logic             stack_trap
);

    // ==========================================================
    // helpers
    // clear the alignment bit of any stack address or limit
    function automatic logic [15:0] slc_align(input logic [15:0] v);
        slc_align = {v[15:1], 1'b0};
    endfunction

    // address above the limit; equal to the limit is still legal
    function automatic logic slc_overflow(input logic [15:0] a, input logic [15:0] lim);
        slc_overflow = a > lim;
    endfunction

    // address inside the special register area below the floor
    function automatic logic slc_underflow(input logic [15:0] a);
        slc_underflow = a < `SLC_UFLOW_BASE;
    endfunction

    // word written by a push; exception beats call when both are set
    function automatic logic [15:0] slc_push_word(
        input logic        exc,
        input logic        call,
        input logic [15:0] d,
        input logic [7:0]  slb
    );
        logic [15:0] w;
        w = d;
        if (exc) begin
            w = {slb, d[7:0]};
        end else if (call) begin
            w = {8'h00, d[7:0]};
        end
        slc_push_word = w;
    endfunction

    // address touched by an operation: the pointer before it moves, or the aligned ea for an EA access
    // pops pre-decrement, so their check uses the decremented address
    function automatic logic [15:0] slc_access_addr(
        input slc_op_t     op,
        input logic [15:0] sp,
        input logic [15:0] ea
    );
        logic [15:0] a;
        a = 16'h0000;
        unique case (op)
            SLC_OP_NONE: a = 16'h0000;
            SLC_OP_PUSH: a = sp;
            SLC_OP_POP:  a = sp - 16'h0002;
            SLC_OP_EA:   a = slc_align(ea);
        endcase
        slc_access_addr = a;
    endfunction

    // read value of a register index; unmapped indices read zero
    function automatic logic [15:0] slc_read_mux(
        input logic [3:0]  idx,
        input logic [15:0] lim,
        input logic [15:0] sp,
        input logic [1:0]  st
    );
        logic [15:0] r;
        r = 16'h0000;
        unique case (idx)
            `SLC_OFF_LIMIT:  r = lim;
            `SLC_OFF_SPTR:   r = sp;
            `SLC_OFF_STATUS: r = {14'h0000, st};
            default:         r = 16'h0000;
        endcase
        slc_read_mux = r;
    endfunction

    // sticky flags: cleared by writing ones, a new event still sets them
    // set is applied after the clear so no event is lost to software
    function automatic logic [1:0] slc_sticky_next(
        input logic [1:0] cur,
        input logic       clr_en,
        input logic [1:0] clr,
        input logic [1:0] set
    );
        logic [1:0] n;
        n = cur;
        if (clr_en) begin
            n = cur & ~clr;
        end
        slc_sticky_next = n | set;
    endfunction

    // ==========================================================
    // state and decoded strobes
    slc_state_t  s_reg;
    slc_state_t  s_next;
    logic [15:0] chk_addr;
    logic        active;
    logic        ovf;
    logic        unf;
    logic [15:0] push_word;
    logic        wr_limit;
    logic        wr_sptr;
    logic        wr_status;

    // decode of the register write strobe
    assign wr_limit  = reg_wr && (reg_addr == `SLC_OFF_LIMIT);
    assign wr_sptr   = reg_wr && (reg_addr == `SLC_OFF_SPTR);
    assign wr_status = reg_wr && (reg_addr == `SLC_OFF_STATUS);

    // ==========================================================
    // access address, limit checks and pushed word
    // limit is unknown until written, so software must set it first
    always_comb begin
        active    = req.op != SLC_OP_NONE;
        chk_addr  = slc_access_addr(req.op, s_reg.working_reg_fifteen, req.ea);
        ovf       = active && slc_overflow(chk_addr, s_reg.stack_limit);
        unf       = active && slc_underflow(chk_addr);
        push_word = slc_push_word(req.exc_push, req.pc_push, req.data, req.status_low_byte);
    end

    // ==========================================================
    // next state
    always_comb begin
        s_next       = s_reg;
        s_next.mem   = '0;
        s_next.trap  = 1'b0;
        s_next.rdata = 16'h0000;
        // stack access and pointer movement
        unique case (req.op)
            SLC_OP_NONE: begin
            end
            SLC_OP_PUSH: begin
                s_next.mem.valid           = 1'b1;
                s_next.mem.write           = 1'b1;
                s_next.mem.addr            = chk_addr;
                s_next.mem.wdata           = push_word;
                s_next.working_reg_fifteen = chk_addr + 16'h0002;
            end
            SLC_OP_POP: begin
                s_next.mem.valid           = 1'b1;
                s_next.mem.write           = 1'b0;
                s_next.mem.addr            = chk_addr;
                s_next.working_reg_fifteen = chk_addr;
            end
            SLC_OP_EA: begin
                s_next.mem.valid = 1'b1;
                s_next.mem.write = 1'b0;
                s_next.mem.addr  = chk_addr;
            end
        endcase
        // one shared trap pulse for both directions
        s_next.trap   = ovf | unf;
        s_next.sticky = slc_sticky_next(s_reg.sticky, wr_status, reg_wdata[1:0], {unf, ovf});
        // limit write, aligned on the way in
        if (wr_limit) begin
            s_next.stack_limit = slc_align(reg_wdata);
        end
        // pointer write beats a push or pop in the same cycle
        if (wr_sptr) begin
            s_next.working_reg_fifteen = slc_align(reg_wdata);
        end
        // read data stand in the following cycle only
        if (reg_rd) begin
            s_next.rdata = slc_read_mux(reg_addr, s_reg.stack_limit,
                                        s_reg.working_reg_fifteen, s_reg.sticky);
        end
    end

    // ==========================================================
    // state register
    // stack_limit deliberately keeps no reset value
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg.working_reg_fifteen <= `SLC_SP_RESET;
            s_reg.mem                 <= '0;
            s_reg.trap                <= 1'b0;
            s_reg.sticky              <= 2'h0;
            s_reg.rdata               <= 16'h0000;
        end else begin
            s_reg.working_reg_fifteen <= s_next.working_reg_fifteen;
            s_reg.mem                 <= s_next.mem;
            s_reg.trap                <= s_next.trap;
            s_reg.sticky              <= s_next.sticky;
            s_reg.rdata               <= s_next.rdata;
        end
        s_reg.stack_limit <= s_next.stack_limit;
    end

    // ==========================================================
    // outputs
    // all outputs come straight from the state register
    assign reg_rdata  = s_reg.rdata;
    assign mem        = s_reg.mem;
    assign stack_trap = s_reg.trap;

endmodule

// ---- pkg/slc_pkg.sv ----
package slc_pkg;
    // kind of stack operation requested by the core
    typedef enum logic [1:0] {
        SLC_OP_NONE = 2'h0,
        SLC_OP_PUSH = 2'h1,
        SLC_OP_POP  = 2'h3,
        SLC_OP_EA   = 2'h2
    } slc_op_t;

    // request from address generation
    typedef struct packed {
        slc_op_t     op;
        logic        exc_push;
        logic        pc_push;
        logic [15:0] ea;
        logic [15:0] data;
        logic [7:0]  status_low_byte;
    } slc_req_t;

    // memory access produced for the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } slc_mem_t;

    // all state of the checker
    typedef struct packed {
        logic [15:0] working_reg_fifteen;
        logic [15:0] stack_limit;
        slc_mem_t    mem;
        logic        trap;
        logic [1:0]  sticky;
        logic [15:0] rdata;
    } slc_state_t;
endpackage

// ---- pkg/slc_regs.svh ----
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH
// ==========================================================
// register offsets (word index on the plain register port)
`define SLC_OFF_LIMIT   4'h0
`define SLC_OFF_SPTR    4'h1
`define SLC_OFF_STATUS  4'h2
// ==========================================================
// field positions and constants
`define SLC_ALIGN_BIT   0
`define SLC_UFLOW_BASE  16'h0800
`define SLC_SP_RESET    16'h0800
`define SLC_ST_OVF      0
`define SLC_ST_UNF      1
`endif
